// ==== hw/sarc_host.sv ====
// host end: issues converts, reads the word on busy rising
// busy pin passes a three-flop synchroniser; the result bus passes a single register
`timescale 1ns/100ps
`default_nettype none
module sarc_host #(
  parameter int PULSE_CYC = sarc_pkg::CONV_PULSE_CYC,
  parameter int GAP_CYC   = sarc_pkg::BETWEEN_CONV_CYC,
  parameter int SETUP_C   = sarc_pkg::SETUP_CYC
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  sarc_if.host             pins,
  input  wire logic        START_IN,
  input  wire logic        CS_TIED_IN,
  output logic             READY_OUT,
  output logic [11:0]      DATA_OUT,
  output logic             DATA_VALID_OUT
);
  logic [2:0]  bz_sync_r, bz_sync_nxt;
  logic        busy_n_r, busy_n_nxt, busy_prev_r, busy_prev_nxt;
  logic [11:0] dq1_r, dq1_nxt;
  sarc_pkg::sarc_host_state_t st_r, st_nxt;
  logic [sarc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic        cs_n_r, cs_n_nxt, rc_r, rc_nxt, rdy_r, rdy_nxt, dv_r, dv_nxt;
  logic [11:0] data_r, data_nxt;

  always_comb begin
    bz_sync_nxt   = {bz_sync_r[1:0], pins.busy_n};
    busy_n_nxt    = (bz_sync_r[1] == bz_sync_r[2]) ? bz_sync_r[2] : busy_n_r;
    busy_prev_nxt = busy_n_r;
    dq1_nxt       = pins.result_bus;
  end

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r + sarc_pkg::CNT_W'(1);
    cs_n_nxt = cs_n_r;
    rc_nxt   = rc_r;
    data_nxt = data_r;
    dv_nxt   = 1'b0;
    rdy_nxt  = 1'b0;
    case (st_r)
      sarc_pkg::SARC_H_IDLE: begin
        cs_n_nxt = !CS_TIED_IN;
        rc_nxt   = 1'b1;
        rdy_nxt  = 1'b1;
        cnt_nxt  = '0;
        if (START_IN) begin
          cs_n_nxt = 1'b0;
          rdy_nxt  = 1'b0;
          st_nxt   = sarc_pkg::SARC_H_SETUP;
        end
      end
      sarc_pkg::SARC_H_SETUP: begin
        if (int'(cnt_r) >= SETUP_C - 1) begin
          rc_nxt  = 1'b0;
          cnt_nxt = '0;
          st_nxt  = sarc_pkg::SARC_H_PULSE;
        end
      end
      sarc_pkg::SARC_H_PULSE: begin
        // held past the synchroniser so the convert is seen
        if (int'(cnt_r) >= PULSE_CYC + 4) begin
          rc_nxt = 1'b1;
          st_nxt = sarc_pkg::SARC_H_WAIT;
        end
      end
      sarc_pkg::SARC_H_WAIT: begin
        // bus left alone until busy rises
        if (busy_n_r && !busy_prev_r) begin
          st_nxt = sarc_pkg::SARC_H_READ;
        end
      end
      sarc_pkg::SARC_H_READ: begin
        if (busy_n_r) begin
          data_nxt = dq1_r;
          dv_nxt   = 1'b1;
          // gap counted from the read, not from the convert pulse
          cnt_nxt  = '0;
          st_nxt   = sarc_pkg::SARC_H_GAP;
        end
      end
      sarc_pkg::SARC_H_GAP: begin
        cs_n_nxt = !CS_TIED_IN;
        if (int'(cnt_r) >= GAP_CYC) begin
          st_nxt = sarc_pkg::SARC_H_IDLE;
        end
      end
      default: begin
        st_nxt = sarc_pkg::SARC_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      bz_sync_r   <= 3'h7;
      busy_n_r    <= 1'b1;
      busy_prev_r <= 1'b1;
      dq1_r       <= 12'h000;
      st_r        <= sarc_pkg::SARC_H_IDLE;
      cnt_r       <= '0;
      cs_n_r      <= 1'b1;
      rc_r        <= 1'b1;
      rdy_r       <= 1'b0;
      dv_r        <= 1'b0;
      data_r      <= 12'h000;
    end else begin
      bz_sync_r   <= bz_sync_nxt;
      busy_n_r    <= busy_n_nxt;
      busy_prev_r <= busy_prev_nxt;
      dq1_r       <= dq1_nxt;
      st_r        <= st_nxt;
      cnt_r       <= cnt_nxt;
      cs_n_r      <= cs_n_nxt;
      rc_r        <= rc_nxt;
      rdy_r       <= rdy_nxt;
      dv_r        <= dv_nxt;
      data_r      <= data_nxt;
    end
  end

  assign pins.cs_n      = cs_n_r;
  assign pins.rd_cnv    = rc_r;
  assign READY_OUT      = rdy_r;
  assign DATA_OUT       = data_r;
  assign DATA_VALID_OUT = dv_r;
endmodule
`default_nettype wire

// ==== hw/sarc_pkg.sv ====
// package for the converter control block: timing counts, codes, states
// assumes a 10 MHz system clock shared by both ends
package sarc_pkg;
  localparam int CLK_HZ          = 10_000_000;
  localparam int CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  localparam int DATA_W          = 12;
  localparam int CONV_PULSE_NS   = 40;
  localparam int CONV_PULSE_CYC  = (CONV_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_VALID_NS   = 1100;
  localparam int DATA_VALID_CYC  = DATA_VALID_NS / CLK_PERIOD_NS;
  localparam int BUSY_DELAY_NS   = 125;
  localparam int BUSY_DELAY_CYC  = BUSY_DELAY_NS / CLK_PERIOD_NS;
  localparam int CONV_TIME_NS    = 940;
  localparam int CONV_TIME_CYC   = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int BETWEEN_CONV_NS = 1250;
  localparam int BETWEEN_CONV_CYC = (BETWEEN_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_NS        = 10;
  localparam int SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 8;
  localparam logic [11:0] CODE_POS_FS = 12'h7FF;
  localparam logic [11:0] CODE_MID    = 12'h000;
  localparam logic [11:0] CODE_M1LSB  = 12'hFFF;
  localparam logic [11:0] CODE_NEG_FS = 12'h800;
  localparam int SAMPLE_FRAC_W   = 12;
  typedef enum logic [1:0] {SARC_IDLE, SARC_ARMED, SARC_CONV} sarc_dev_state_t;
  typedef enum logic [2:0] {SARC_H_IDLE, SARC_H_SETUP, SARC_H_PULSE, SARC_H_WAIT, SARC_H_READ,
                            SARC_H_GAP} sarc_host_state_t;
endpackage

// ==== hw/sarc_if.sv ====
// pins between the converter and its host
// result_bus is read as driven; result_oe is a separate flag that nothing resolves
`timescale 1ns/100ps
`default_nettype none
interface sarc_if;
  logic        cs_n;
  logic        rd_cnv;
  logic        busy_n;
  logic [11:0] result_bus;
  logic        result_oe;
  modport dev  (input cs_n, input rd_cnv, output busy_n, output result_bus, output result_oe);
  modport host (output cs_n, output rd_cnv, input busy_n, input result_bus, input result_oe);
endinterface
`default_nettype wire

// ==== hw/sarc_dev.sv ====
// converter end: control, busy, result register, output enable
// pins from host pass a three-flop synchroniser; sample word is a plain input
`timescale 1ns/100ps
`default_nettype none
module sarc_dev #(
  parameter int CONV_CYC  = sarc_pkg::CONV_TIME_CYC,
  parameter int PULSE_CYC = sarc_pkg::CONV_PULSE_CYC
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  sarc_if.dev              pins,
  input  wire logic [11:0] SAMPLE_IN,
  output logic             CONV_START_OUT,
  output logic             CONV_DONE_OUT
);
  logic [2:0] cs_sync_r, cs_sync_nxt;
  logic [2:0] rc_sync_r, rc_sync_nxt;
  logic       cs_n_r, cs_n_nxt, rc_r, rc_nxt;
  sarc_pkg::sarc_dev_state_t st_r, st_nxt;
  logic [sarc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [11:0] hold_r, hold_nxt, result_r, result_nxt;
  logic        busy_n_r, busy_n_nxt, oe_r, oe_nxt, start_r, start_nxt, done_r, done_nxt;
  logic        low_both;

  always_comb begin
    cs_sync_nxt = {cs_sync_r[1:0], pins.cs_n};
    rc_sync_nxt = {rc_sync_r[1:0], pins.rd_cnv};
    cs_n_nxt    = (cs_sync_r[1] == cs_sync_r[2]) ? cs_sync_r[2] : cs_n_r;
    rc_nxt      = (rc_sync_r[1] == rc_sync_r[2]) ? rc_sync_r[2] : rc_r;
  end

  // level AND of the low states; either may fall first
  assign low_both = !(cs_n_r | rc_r);

  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    hold_nxt   = hold_r;
    result_nxt = result_r;
    busy_n_nxt = busy_n_r;
    start_nxt  = 1'b0;
    done_nxt   = 1'b0;
    case (st_r)
      sarc_pkg::SARC_IDLE: begin
        if (low_both) begin
          st_nxt  = sarc_pkg::SARC_ARMED;
          cnt_nxt = sarc_pkg::CNT_W'(1);
        end
      end
      sarc_pkg::SARC_ARMED: begin
        if (!low_both) begin
          st_nxt = sarc_pkg::SARC_IDLE;
        end else if (int'(cnt_r) >= PULSE_CYC - 1) begin
          // hold the sample, busy falls next edge
          st_nxt     = sarc_pkg::SARC_CONV;
          hold_nxt   = SAMPLE_IN;
          busy_n_nxt = 1'b0;
          start_nxt  = 1'b1;
          cnt_nxt    = '0;
        end else begin
          cnt_nxt = cnt_r + sarc_pkg::CNT_W'(1);
        end
      end
      sarc_pkg::SARC_CONV: begin
        // control lines not looked at here
        cnt_nxt = cnt_r + sarc_pkg::CNT_W'(1);
        if (int'(cnt_r) >= CONV_CYC - 1) begin
          result_nxt = hold_r;
          busy_n_nxt = 1'b1;
          done_nxt   = 1'b1;
          cnt_nxt    = '0;
          st_nxt     = sarc_pkg::SARC_IDLE;
        end
      end
      default: begin
        st_nxt     = sarc_pkg::SARC_IDLE;
        busy_n_nxt = 1'b1;
      end
    endcase
    // bus enabled with read high, selected and idle
    oe_nxt = rc_r && !cs_n_r && busy_n_nxt;
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      cs_sync_r <= 3'h7;
      rc_sync_r <= 3'h7;
      cs_n_r    <= 1'b1;
      rc_r      <= 1'b1;
      st_r      <= sarc_pkg::SARC_IDLE;
      cnt_r     <= '0;
      hold_r    <= sarc_pkg::CODE_MID;
      result_r  <= sarc_pkg::CODE_MID;
      busy_n_r  <= 1'b1;
      oe_r      <= 1'b0;
      start_r   <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      cs_sync_r <= cs_sync_nxt;
      rc_sync_r <= rc_sync_nxt;
      cs_n_r    <= cs_n_nxt;
      rc_r      <= rc_nxt;
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      hold_r    <= hold_nxt;
      result_r  <= result_nxt;
      busy_n_r  <= busy_n_nxt;
      oe_r      <= oe_nxt;
      start_r   <= start_nxt;
      done_r    <= done_nxt;
    end
  end

  assign pins.busy_n     = busy_n_r;
  assign pins.result_bus = result_r;
  assign pins.result_oe  = oe_r;
  assign CONV_START_OUT  = start_r;
  assign CONV_DONE_OUT   = done_r;
endmodule
`default_nettype wire

// ==== dv/sarc_asserts.sv ====
// checker for the converter pins between host and converter
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module sarc_asserts (
  input wire logic        CLK_IN,
  input wire logic        RST_IN,
  input wire logic        cs_n,
  input wire logic        rd_cnv,
  input wire logic        busy_n,
  input wire logic [11:0] result_bus,
  input wire logic        result_oe
);
  logic [3:0] lo_age_r;
  logic [3:0] lo_age_nxt;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // cycles since both control lines were last low
  always_comb begin
    lo_age_nxt = lo_age_r;
    if (!cs_n && !rd_cnv)
      lo_age_nxt = 4'h0;
    else if (lo_age_r != 4'hF)
      lo_age_nxt = lo_age_r + 4'h1;
  end
  always_ff @(posedge CLK_IN) begin
    lo_age_r <= RST_IN ? 4'hF : lo_age_nxt;
  end
  busy_len_a: assert property ($fell(busy_n) |-> ##1 (!busy_n) [*8] ##1 busy_n)
    else $error("busy low time wrong");
  busy_max_a: assert property ($fell(busy_n) |-> ##[1:11] busy_n)
    else $error("result late");
  oe_busy_a: assert property (!busy_n |-> !result_oe)
    else $error("bus driven while busy");
  oe_off_a: assert property ((cs_n || !rd_cnv) [*6] |-> !result_oe)
    else $error("bus driven while not read");
  oe_on_a: assert property ((!cs_n && rd_cnv && busy_n) [*6] |-> result_oe)
    else $error("bus not driven in read");
  start_a: assert property ((busy_n && !cs_n && !rd_cnv) [*2] |-> ##[0:5] !busy_n)
    else $error("convert not started");
  cause_a: assert property ($fell(busy_n) |-> lo_age_r <= 4'h6)
    else $error("busy without convert");
  hold_a: assert property (busy_n && $past(busy_n) && result_oe && $past(result_oe) |-> $stable(result_bus))
    else $error("result changed while idle");
  cover property ($rose(busy_n));
  cover property ($rose(result_oe));
  cover property (!cs_n && !rd_cnv && busy_n);
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// bench: host and converter joined, plus a second converter driven by hand
// assumes the hw/ files are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk;
  logic        rst;
  logic [11:0] smp;
  logic        start;
  logic        tied;
  logic        rdy;
  logic [11:0] dat;
  logic        dv;
  logic        b_start;
  logic        b_done;
  int          n_fail;
  int          num_checks;
  sarc_if lnk ();
  sarc_if brk ();
  sarc_dev sarc_dev_i (.CLK_IN(clk), .RST_IN(rst), .pins(lnk), .SAMPLE_IN(smp), .CONV_START_OUT(), .CONV_DONE_OUT());
  sarc_dev sarc_dev_b_i (.CLK_IN(clk), .RST_IN(rst), .pins(brk), .SAMPLE_IN(smp), .CONV_START_OUT(b_start),
                         .CONV_DONE_OUT(b_done));
  sarc_host sarc_host_i (.CLK_IN(clk), .RST_IN(rst), .pins(lnk), .START_IN(start), .CS_TIED_IN(tied),
                         .READY_OUT(rdy), .DATA_OUT(dat), .DATA_VALID_OUT(dv));
  sarc_asserts sarc_asserts_i (.CLK_IN(clk), .RST_IN(rst), .cs_n(lnk.cs_n), .rd_cnv(lnk.rd_cnv),
                               .busy_n(lnk.busy_n), .result_bus(lnk.result_bus), .result_oe(lnk.result_oe));
  task stop_test;
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  // 0 ready, 1 data valid, 2 second busy low, 3 second busy high
  task wt(input int k);
    int n;
    n = 0;
    while (!((k == 0 && rdy === 1'b1) || (k == 1 && dv === 1'b1) ||
             (k == 2 && brk.busy_n === 1'b0) || (k == 3 && brk.busy_n === 1'b1))) begin
      @(posedge clk);
      n++;
      if (n > 200) begin
        n_fail++;
        $display("unexpected %0t wait expired", $time);
        stop_test;
      end
    end
  endtask
  task conv(input logic [11:0] code);
    wt(0);
    smp   <= code;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    wt(1);
    chk(dat, code);
  endtask
  task t_codes;
    logic [11:0] tbl [5];
    tbl = '{12'h7FF, 12'h000, 12'hFFF, 12'h800, 12'hA5C};
    foreach (tbl[i])
      conv(tbl[i]);
  endtask
  task t_ignore;
    smp        <= 12'h5A3;
    brk.rd_cnv <= 1'b0;
    @(posedge clk);
    brk.cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    brk.rd_cnv <= 1'b1;
    wt(2);
    chk({11'h000, b_start}, 12'h001);
    smp        <= 12'h0C1;
    brk.rd_cnv <= 1'b0;
    repeat (2) @(posedge clk);
    brk.rd_cnv <= 1'b1;
    wt(3);
    chk({11'h000, b_done}, 12'h001);
    repeat (12) begin
      @(posedge clk);
      chk({11'h000, brk.busy_n}, 12'h001);
      chk({11'h000, b_start}, 12'h000);
    end
    chk({11'h000, brk.result_oe}, 12'h001);
    chk(brk.result_bus, 12'h5A3);
    brk.cs_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk({11'h000, brk.result_oe}, 12'h000);
    brk.cs_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk(brk.result_bus, 12'h5A3);
  endtask
  task t_tied;
    wt(0);
    tied <= 1'b1;
    @(posedge clk);
    conv(12'h3C6);
    repeat (8) @(posedge clk);
    chk({11'h000, lnk.result_oe}, 12'h001);
    chk(lnk.result_bus, 12'h3C6);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst        = 1'b1;
    smp        = 12'h000;
    start      = 1'b0;
    tied       = 1'b0;
    brk.cs_n   = 1'b1;
    brk.rd_cnv = 1'b1;
    n_fail     = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_codes;
    t_ignore;
    t_tied;
    stop_test;
  end
endmodule
`default_nettype wire
